// [include/asrc_pkg.sv]
// package for the async static ram controller
// assumes a single 40 MHz core clock, no bus-reachable registers
package asrc_pkg;
  // ----------------------------------------
  // geometry limits
  // ----------------------------------------
  localparam int ASRC_DEPTH_MIN = 16;
  localparam int ASRC_DEPTH_MAX = 512;
  localparam int ASRC_DEPTH_STEP = 16;
  localparam int ASRC_WIDTH_MIN = 1;
  localparam int ASRC_WIDTH_MAX = 64;
  localparam int ASRC_BITS_MAX = 32768;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int ASRC_CLK_PERIOD_PS = 25000;
  // strobe width and settle time, generous against the macro's access figures
  localparam int ASRC_STROBE_NS = 25;
  localparam int ASRC_ACCESS_NS = 50;
  localparam int ASRC_STROBE_CYC =
    (ASRC_STROBE_NS * 1000 + ASRC_CLK_PERIOD_PS - 1) / ASRC_CLK_PERIOD_PS;
  localparam int ASRC_ACCESS_CYC =
    (ASRC_ACCESS_NS * 1000 + ASRC_CLK_PERIOD_PS - 1) / ASRC_CLK_PERIOD_PS;
  // ----------------------------------------
  // modes and states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ASRC_WR_BY_RW = 2'b00,
    ASRC_WR_BY_CS = 2'b01
  } asrc_wmode_e;
  typedef enum logic [2:0] {
    ASRC_IDLE = 3'b000,
    ASRC_SETUP = 3'b001,
    ASRC_PULSE = 3'b010,
    ASRC_HOLD = 3'b011,
    ASRC_READ = 3'b100,
    ASRC_DONE = 3'b101
  } asrc_state_e;
endpackage : asrc_pkg

// [include/asrc_seq_if.sv]
// request/answer bundle between controller and its timing sequencer
// assumes both ends run on core_clk
`timescale 1ns/10ps
interface asrc_seq_if;
  logic start;
  logic is_write;
  logic [1:0] wmode;
  logic strobe;
  logic cs_level;
  logic rw_level;
  logic sample;
  logic busy;
  modport ctrl (output start, output is_write, output wmode, input strobe,
    input cs_level, input rw_level, input sample, input busy);
  modport seq (input start, input is_write, input wmode, output strobe,
    output cs_level, output rw_level, output sample, output busy);
endinterface : asrc_seq_if

// [logic/asrc_seq.sv]
// strobe sequencer: shapes setup, write pulse, hold and read settle
// assumes requests only while busy is low
`timescale 1ns/10ps
module asrc_seq
  import asrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  asrc_seq_if.seq sq
);
  asrc_state_e state;
  logic [7:0] cnt;
  logic wr;
  logic [1:0] wm;

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ASRC_IDLE;
      cnt <= 8'h00;
      wr <= 1'b0;
      wm <= 2'h0;
    end else begin
      case (state)
        ASRC_IDLE: begin
          if (sq.start) begin
            wr <= sq.is_write;
            wm <= sq.wmode;
            state <= sq.is_write ? ASRC_SETUP : ASRC_READ;
            cnt <= 8'(ASRC_ACCESS_CYC);
          end
        end
        ASRC_SETUP: begin
          state <= ASRC_PULSE;
          cnt <= 8'(ASRC_STROBE_CYC);
        end
        ASRC_PULSE: begin
          if (cnt <= 8'h01) begin
            state <= ASRC_HOLD;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ASRC_HOLD: state <= ASRC_DONE;
        ASRC_READ: begin
          if (cnt <= 8'h01) begin
            state <= ASRC_DONE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ASRC_DONE: state <= ASRC_IDLE;
        default: state <= ASRC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pin levels
  // ----------------------------------------
  always_comb begin
    sq.strobe = (state == ASRC_PULSE);
    sq.busy = (state != ASRC_IDLE);
    sq.sample = (state == ASRC_READ) && (cnt <= 8'h01);
    if (!wr || state == ASRC_IDLE) begin
      // read: cs and rw both high while settling
      sq.cs_level = (state == ASRC_READ);
      sq.rw_level = 1'b1;
    end else if (wm == 2'(ASRC_WR_BY_CS)) begin
      // rw held low, cs carries the pulse
      sq.cs_level = (state == ASRC_PULSE);
      sq.rw_level = 1'b0;
    end else begin
      // cs held high, rw carries a low pulse
      sq.cs_level = 1'b1;
      sq.rw_level = (state != ASRC_PULSE);
    end
  end
endmodule : asrc_seq

// [logic/asrc_ctrl.sv]
// controller driving an async static ram macro, single or dual port
// assumes the macro sits on chip; its output is sampled through three flops
`timescale 1ns/10ps
// ----------------------------------------
// Overview of operation
// [RL1] depth 16 to 512 words in steps of 16
// [RL2] word width 1 to 64 bits
// [RL3] one macro holds at most 32 K bits
// [RL4] larger memories are built by combining several macros
// [RL5] single port: one shared address, data in and data out
// [RL6] dual port: separate read and store addresses
// [RL7] chip select active high
// [RL8] single port rw high reads, low writes
// [RL9] bit 0 is least significant on every bus
// [RL10] single port with chip select low waits, output undefined
// [RL11] single port read: cs and rw high, stable address
// [RL12] write by holding cs high and pulsing rw low
// [RL13] write by holding rw low and pulsing cs high
// [RL14] data latched on trailing edge of the write pulse
// [RL15] dual port read and store enables active high
// [RL16] dual port read: cs and read enable high, stable read address
// [RL17] dual port write: cs high, pulse store enable high
// [RL18] dual port write: store enable high, pulse cs high
// [RL19] concurrent read and write never to the same address
// [RL20] read access time holds only for completed writes
// [RL21] dual port waits when cs low or both enables low
// [RL22] same-address concurrent access reads unknown
// ----------------------------------------
module asrc_ctrl
  import asrc_pkg::*;
#(
  parameter int DEPTH = 512,
  parameter int WIDTH = 64,
  parameter bit DUAL = 1'b0
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_by_cs,
  input wire logic [$clog2(DEPTH)-1:0] req_addr,
  input wire logic [WIDTH-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [WIDTH-1:0] rsp_rdata,
  output logic ram_cs,
  output logic ram_rw,
  output logic ram_rd_en,
  output logic ram_st_en,
  output logic [$clog2(DEPTH)-1:0] shared_address,
  output logic [$clog2(DEPTH)-1:0] read_address,
  output logic [$clog2(DEPTH)-1:0] store_address,
  output logic [WIDTH-1:0] data_in_bus,
  input wire logic [WIDTH-1:0] data_out_bus
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------
  // geometry checks at elaboration
  // ----------------------------------------
  if (DEPTH < ASRC_DEPTH_MIN || DEPTH > ASRC_DEPTH_MAX || DEPTH % ASRC_DEPTH_STEP != 0) begin
    $error("depth out of range"); // [RL1]
  end
  if (WIDTH < ASRC_WIDTH_MIN || WIDTH > ASRC_WIDTH_MAX) begin
    $error("width out of range"); // [RL2]
  end
  if (DEPTH * WIDTH > ASRC_BITS_MAX) begin
    // wider or deeper memories need several macros side by side
    $error("macro capacity exceeded"); // [RL3] [RL4]
  end

  asrc_seq_if sq ();
  asrc_seq u_seq (
    .core_clk(core_clk),
    .rst(rst),
    .sq(sq)
  );

  logic pend;
  logic pend_wr;
  logic pend_cs;
  logic [AW-1:0] pend_addr;
  logic [WIDTH-1:0] pend_data;
  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] sync3;
  logic [1:0] smp_pipe;

  // two late stages agreeing means the macro output has stopped moving
  function automatic logic data_settled(input logic [WIDTH-1:0] late,
    input logic [WIDTH-1:0] later);
    return late == later;
  endfunction : data_settled

  // ----------------------------------------
  // request capture
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend <= 1'b0;
      pend_wr <= 1'b0;
      pend_cs <= 1'b0;
      pend_addr <= '0;
      pend_data <= '0;
    end else if (req_valid && req_ready) begin
      pend <= 1'b1;
      pend_wr <= req_write;
      pend_cs <= req_by_cs;
      pend_addr <= req_addr; // [RL9]
      pend_data <= req_wdata; // [RL9]
    end else begin
      pend <= 1'b0;
    end
  end

  always_comb begin
    sq.start = pend;
    sq.is_write = pend_wr;
    sq.wmode = pend_cs ? ASRC_WR_BY_CS : ASRC_WR_BY_RW;
  end

  // ----------------------------------------
  // request/answer handshake
  // ----------------------------------------
  // one access at a time so a read never overlaps an unfinished write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_ready <= 1'b0;
    end else if (req_valid && req_ready) begin
      req_ready <= 1'b0; // [RL20] [RL19]
    end else begin
      req_ready <= !pend && !sq.busy && !(smp_pipe != 2'b00) && !rsp_valid;
    end
  end

  // ----------------------------------------
  // address and data pins, all from flops
  // ----------------------------------------
  // one request address feeds every address bus; the unused one just idles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shared_address <= '0;
      read_address <= '0;
      store_address <= '0;
      data_in_bus <= '0;
    end else begin
      shared_address <= pend_addr; // [RL5] [RL11]
      read_address <= pend_addr; // [RL6] [RL16]
      store_address <= pend_addr; // [RL6]
      data_in_bus <= pend_data; // [RL14]
    end
  end

  // ----------------------------------------
  // strobe pins, all from flops
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ram_cs <= 1'b0; // [RL10] [RL21]
      ram_rw <= 1'b1;
      ram_rd_en <= 1'b0;
      ram_st_en <= 1'b0;
    end else begin
      if (!DUAL) begin
        ram_cs <= sq.cs_level; // [RL7] [RL13]
        ram_rw <= sq.rw_level; // [RL8] [RL12]
        ram_rd_en <= 1'b0;
        ram_st_en <= 1'b0;
      end else if (sq.busy && sq.is_write && pend_cs) begin
        ram_cs <= sq.strobe; // [RL18]
        ram_st_en <= 1'b1;
        ram_rd_en <= 1'b0;
        ram_rw <= 1'b1;
      end else begin
        ram_cs <= sq.busy; // [RL7] [RL21]
        ram_st_en <= sq.busy && sq.is_write && sq.strobe; // [RL15] [RL17]
        ram_rd_en <= sq.busy && !sq.is_write; // [RL15] [RL16]
        ram_rw <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // read data capture
  // ----------------------------------------
  // macro output is asynchronous; three stages, accept once last two agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= data_out_bus;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      smp_pipe <= 2'b00;
    end else if (sq.sample) begin
      smp_pipe <= 2'b01;
    end else if (smp_pipe == 2'b01 || (smp_pipe == 2'b10 && !data_settled(sync2, sync3))) begin
      // hold the answer back while the late stages still disagree
      smp_pipe <= 2'b10;
    end else begin
      smp_pipe <= 2'b00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else if (smp_pipe == 2'b10 && data_settled(sync2, sync3)) begin
      rsp_valid <= 1'b1;
      rsp_rdata <= sync3; // [RL11] [RL16]
    end else begin
      rsp_valid <= 1'b0;
    end
  end
endmodule : asrc_ctrl

// [tb/asrc_checker.sv]
// checker for the static ram controller ports
// assumes a bind from the testbench; one clock domain
`timescale 1ns/10ps
module asrc_checker #(
  parameter int DEPTH = 512,
  parameter int WIDTH = 64,
  parameter bit DUAL = 1'b0
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_by_cs,
  input wire logic [$clog2(DEPTH)-1:0] req_addr,
  input wire logic [WIDTH-1:0] req_wdata,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [WIDTH-1:0] rsp_rdata,
  input wire logic ram_cs,
  input wire logic ram_rw,
  input wire logic ram_rd_en,
  input wire logic ram_st_en,
  input wire logic [$clog2(DEPTH)-1:0] shared_address,
  input wire logic [$clog2(DEPTH)-1:0] read_address,
  input wire logic [$clog2(DEPTH)-1:0] store_address,
  input wire logic [WIDTH-1:0] data_in_bus,
  input wire logic [WIDTH-1:0] data_out_bus
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [$clog2(DEPTH)-1:0] ha;
  logic [WIDTH-1:0] hd;
  wire take = req_valid && req_ready;
  wire wr_on = ram_cs && (DUAL ? ram_st_en : !ram_rw);
  wire rd_on = ram_cs && (DUAL ? ram_rd_en : ram_rw);
  wire [$clog2(DEPTH)-1:0] wa = DUAL ? store_address : shared_address;
  wire [$clog2(DEPTH)-1:0] ra = DUAL ? read_address : shared_address;
  always_ff @(posedge core_clk) begin
    if (take) begin
      ha <= req_addr;
      hd <= req_wdata;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_IDLE_WAIT: assert property (req_ready |-> !ram_cs)
    else $error("chip select high while idle");
  AST_READ_PINS: assert property (take && !req_write |-> ##[1:4] rd_on)
    else $error("read strobes missing");
  AST_READ_LAT: assert property (take && !req_write |-> ##[6:12] rsp_valid)
    else $error("read answer late");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  AST_WR_PULSE: assert property (take && req_write |-> ##[1:6] wr_on)
    else $error("write pulse missing");
  AST_WR_STABLE: assert property (wr_on |=> $stable(data_in_bus) && $stable(wa))
    else $error("write data moved at trailing edge");
  AST_WR_ADDR: assert property (wr_on |-> wa == ha && data_in_bus == hd)
    else $error("write address or data wrong");
  AST_RD_ADDR: assert property (rd_on |-> ra == ha)
    else $error("read address wrong");
  AST_NO_CLASH: assert property (ram_st_en |-> !ram_rd_en)
    else $error("read and store enables high together");
  cover property (take && req_write && req_by_cs);
  cover property (take && req_write && !req_by_cs);
  cover property (rsp_valid);
endmodule : asrc_checker

// [tb/asrc_ram_model.sv]
// model of the static ram macro, single or dual port
// assumes pins driven by the controller under test
`timescale 1ns/10ps
module asrc_ram_model #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8,
  parameter bit DUAL = 1'b0
)(
  input wire logic ram_cs,
  input wire logic ram_rw,
  input wire logic ram_rd_en,
  input wire logic ram_st_en,
  input wire logic [$clog2(DEPTH)-1:0] shared_address,
  input wire logic [$clog2(DEPTH)-1:0] read_address,
  input wire logic [$clog2(DEPTH)-1:0] store_address,
  input wire logic [WIDTH-1:0] data_in_bus,
  output logic [WIDTH-1:0] data_out_bus
);
  logic [WIDTH-1:0] mem [DEPTH];
  wire wr_on = ram_cs && (DUAL ? ram_st_en : !ram_rw);
  wire rd_on = ram_cs && (DUAL ? ram_rd_en : ram_rw);
  wire [$clog2(DEPTH)-1:0] wa = DUAL ? store_address : shared_address;
  wire [$clog2(DEPTH)-1:0] ra = DUAL ? read_address : shared_address;
  // trailing edge of whichever strobe carries the pulse
  always @(negedge wr_on) begin
    mem[wa] <= data_in_bus;
  end
  // not reading: inverse of the addressed word, so a stale sample shows up
  assign data_out_bus = (DUAL && rd_on && wr_on && ra == wa) ? 'x :
    rd_on ? mem[ra] : ~mem[ra];
endmodule : asrc_ram_model

// [tb/asrc_ctrl_tb.sv]
// testbench: a single-port and a dual-port controller side by side
// assumes each faces its own ram model
`timescale 1ns/10ps
module asrc_ctrl_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic vs = 1'b0;
  logic vd = 1'b0;
  logic wr = 1'b0;
  logic bycs = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00;
  logic [1:0] got = 2'b00;
  logic [7:0] val [2];
  wire [1:0] rdy;
  wire [1:0] rv;
  wire [7:0] rd [2];
  int fails = 0;
  int checks_done = 0;
  for (genvar g = 0; g < 2; g++) begin : gen
    wire cs, rw, re, se;
    wire [3:0] sa, ra, wa;
    wire [7:0] di, dq;
    asrc_ctrl #(.DEPTH(16), .WIDTH(8), .DUAL(g == 1)) u_asrc_ctrl (
      .core_clk(core_clk), .rst(rst), .req_valid(g == 1 ? vd : vs),
      .req_write(wr), .req_by_cs(bycs), .req_addr(addr), .req_wdata(wd),
      .req_ready(rdy[g]), .rsp_valid(rv[g]), .rsp_rdata(rd[g]), .ram_cs(cs),
      .ram_rw(rw), .ram_rd_en(re), .ram_st_en(se), .shared_address(sa),
      .read_address(ra), .store_address(wa), .data_in_bus(di), .data_out_bus(dq));
    asrc_ram_model #(.DEPTH(16), .WIDTH(8), .DUAL(g == 1)) u_asrc_ram_model (
      .ram_cs(cs), .ram_rw(rw), .ram_rd_en(re), .ram_st_en(se), .shared_address(sa),
      .read_address(ra), .store_address(wa), .data_in_bus(di), .data_out_bus(dq));
    always @(posedge core_clk) begin
      if (rv[g]) begin
        got[g] <= 1'b1;
        val[g] <= rd[g];
      end
    end
  end
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // each controller's valid is dropped once that controller takes it
  task automatic req(input logic w, input logic c, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    got <= 2'b00;
    vs <= 1'b1;
    vd <= 1'b1;
    wr <= w;
    bycs <= c;
    addr <= a;
    wd <= d;
    do begin
      @(posedge core_clk);
      if (rdy[0]) vs <= 1'b0;
      if (rdy[1]) vd <= 1'b0;
      n++;
    end while ((vs || vd) && n < 60);
    @(posedge core_clk);
    chk({6'h00, vs, vd}, 8'h00);
  endtask : req
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    int n;
    req(1'b0, 1'b0, a, 8'h00);
    for (n = 0; n < 20 && got !== 2'b11; n++) @(posedge core_clk);
    chk({6'h00, got}, 8'h03);
    chk(val[0], e);
    chk(val[1], e);
  endtask : rd_chk
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rw_write;
    req(1'b1, 1'b0, 4'h1, 8'hA5);
    rd_chk(4'h1, 8'hA5);
    $display("test rw_write done");
  endtask : t_rw_write
  task automatic t_cs_write;
    req(1'b1, 1'b1, 4'h2, 8'h3C);
    rd_chk(4'h2, 8'h3C);
    rd_chk(4'h1, 8'hA5);
    $display("test cs_write done");
  endtask : t_cs_write
  task automatic t_edges;
    req(1'b1, 1'b0, 4'h0, 8'h01);
    req(1'b1, 1'b1, 4'hF, 8'h80);
    rd_chk(4'h0, 8'h01);
    rd_chk(4'hF, 8'h80);
    $display("test edges done");
  endtask : t_edges
  task automatic t_overwrite;
    req(1'b1, 1'b0, 4'h2, 8'hC3);
    req(1'b1, 1'b1, 4'h2, 8'h7E);
    rd_chk(4'h2, 8'h7E);
    rd_chk(4'h2, 8'h7E);
    $display("test overwrite done");
  endtask : t_overwrite
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_rw_write;
    t_cs_write;
    t_edges;
    t_overwrite;
    give_verdict;
  end
  // about eighteen times the expected run
  initial begin
    #50000;
    fails++;
    give_verdict;
  end
endmodule : asrc_ctrl_tb
bind asrc_ctrl asrc_checker #(.DEPTH(DEPTH), .WIDTH(WIDTH), .DUAL(DUAL)) u_asrc_checker (.*);
